// file: rtl/spi_reg_pkg.sv
// Function
// - four-wire full-duplex serial slave exchanging sixteen-bit frames
// - select high: clock and data ignored, serial output released
// - before first rising clock edge output shows any-diagnosis-bit-set flag
// - select rising ends frame; length and command checked; valid executed
// - input sampled on falling clock edge, output changes after rising edge
// - command and response words travel most significant bit first
// - frames not exactly sixteen bits long are discarded
// - answer to a frame is sent during the following frame
// - three registers: command, diagnosis and status
// - power-on reset puts every register bit to its reset value
// - valid command write answers write bit 1, address 00, command contents
// - valid reads answer write bit 0 and addressed register contents
// - anything but command write or listed reads is an invalid message
// - during power-on reset commands ignored and serial output held low
// - first frame after power-on reset sends command register
// - during watchdog reset commands ignored, output carries diagnosis flag
// - after watchdog overflow first frame after reset release sends status
// - after valid read or write the selected register is sent next
// - after invalid communication the diagnosis register is sent next
// - two-bit threshold select drives the negative detection threshold
// - two-bit load select drives the sensor load resistance
// - frame bit 15 is read/write, bits 14 to 13 register address
// - command bits 0-2 channel on, 10-9 load, 12-11 threshold select
package spi_reg_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam int DATA_W = 13;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
  localparam logic [CNT_W-1:0] CNT_TOP = 5'h0f;
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_DIAG = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;
  localparam logic [1:0] ADDR_NONE = 2'h3;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CH_ON_LO = 0;
  localparam int CH_ON_HI = 2;
  localparam int LOAD_LO = 9;
  localparam int LOAD_HI = 10;
  localparam int THR_LO = 11;
  localparam int THR_HI = 12;
  localparam logic [DATA_W-1:0] CMD_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] CMD_MASK = 13'h1e07;
  localparam logic [DATA_W-1:0] DATA_ZERO = 13'h0000;

  typedef struct packed {
    logic rw;
    logic [1:0] addr;
    logic [DATA_W-1:0] data;
  } spi_word_type;

  typedef enum logic {
    st_idle,
    st_frame
  } link_state_type;

endpackage

// file: rtl/spi_slave_register_access.sv
module spi_slave_register_access (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic select_low,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  input wire logic por_active,
  input wire logic reset_output_low,
  input wire logic [spi_reg_pkg::DATA_W-1:0] diag_in,
  input wire logic [spi_reg_pkg::DATA_W-1:0] status_in,
  output logic [2:0] channel_on,
  output logic [1:0] load_select,
  output logic [1:0] threshold_select,
  output logic frame_ok,
  output logic frame_bad
);
  import spi_reg_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_raw;
  logic [2:0] sync2_r;
  logic cs_low_s;
  logic por_s;
  logic nro_s;

  assign pins_raw = {reset_output_low, por_active, select_low};

  // reset select and watchdog pins to idle and power-on to active, so no false edge follows sys_rst
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic s1_r;
    logic s2_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
      end else begin
        s1_r <= pins_raw[i];
        s2_r <= s1_r;
      end
    end

    assign sync2_r[i] = s2_r;
  end

  assign cs_low_s = ~sync2_r[0];
  assign por_s = sync2_r[1];
  assign nro_s = sync2_r[2];

  // ----------------------------------------------------------------
  // reset phase tracking
  // ----------------------------------------------------------------
  logic por_d_r;
  logic nro_d_r;
  logic wd_s;
  logic blocked;
  logic por_fall;
  logic nro_rise;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      por_d_r <= 1'b1;
      nro_d_r <= 1'b1;
    end else begin
      por_d_r <= por_s;
      nro_d_r <= nro_s;
    end
  end

  assign wd_s = ~nro_s & ~por_s;
  assign blocked = por_s | wd_s;
  assign por_fall = por_d_r & ~por_s;
  assign nro_rise = ~nro_d_r & nro_s & ~por_s;

  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  link_state_type state_r;
  logic link_clr_r;
  logic link_rst;
  logic frame_end;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: begin
          if (cs_low_s) begin
            state_r <= st_frame;
          end
        end
        st_frame: begin
          if (!cs_low_s) begin
            state_r <= st_idle;
          end
        end
        default: begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  // link logic is held cleared between frames
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      link_clr_r <= 1'b1;
    end else if (state_r == st_idle && cs_low_s) begin
      link_clr_r <= 1'b0;
    end else if (state_r != st_idle && !cs_low_s) begin
      link_clr_r <= 1'b1;
    end
  end

  assign frame_end = (state_r == st_frame) && !cs_low_s;
  assign link_rst = sys_rst | link_clr_r;

  // ----------------------------------------------------------------
  // link domain: receive on falling edge
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_r;
  logic [CNT_W-1:0] rx_cnt_r;

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      rx_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      rx_r <= {rx_r[FRAME_BITS-2:0], serial_in};
      if (rx_cnt_r != CNT_SAT) begin
        rx_cnt_r <= rx_cnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain: transmit after rising edge
  // ----------------------------------------------------------------
  spi_word_type resp_word_r;
  logic [CNT_W-1:0] tx_cnt_r;
  logic so_r;
  logic [3:0] tx_idx;
  logic tx_bit;

  assign tx_idx = 4'(CNT_TOP - tx_cnt_r);
  assign tx_bit = (tx_cnt_r > CNT_TOP) ? 1'b0 : resp_word_r[tx_idx];

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      tx_cnt_r <= '0;
      so_r <= 1'b0;
    end else begin
      so_r <= tx_bit;
      if (tx_cnt_r != CNT_SAT) begin
        tx_cnt_r <= tx_cnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output selection
  // ----------------------------------------------------------------
  logic flag_r;
  logic mode_por_r;
  logic mode_wd_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= |diag_in;
    end
  end

  // sys_rst counts as power-on: output low until the pins say otherwise
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_por_r <= 1'b1;
      mode_wd_r <= 1'b0;
    end else begin
      mode_por_r <= por_s;
      mode_wd_r <= wd_s;
    end
  end

  always_comb begin
    if (mode_por_r) begin
      serial_out = 1'b0;
    end else if (mode_wd_r) begin
      serial_out = flag_r;
    end else if (tx_cnt_r == '0) begin
      serial_out = flag_r;
    end else begin
      serial_out = so_r;
    end
  end

  assign serial_out_oe_n = select_low;

  // ----------------------------------------------------------------
  // frame checking
  // ----------------------------------------------------------------
  spi_word_type rx_word;
  logic len_ok;
  logic is_wr;
  logic is_rd;
  logic cmd_ok;
  logic exec;

  assign rx_word = spi_word_type'(rx_r);
  assign len_ok = (rx_cnt_r == CNT_FULL);
  assign is_wr = rx_word.rw && (rx_word.addr == ADDR_CMD);
  assign is_rd = !rx_word.rw && (rx_word.addr != ADDR_NONE);
  assign cmd_ok = len_ok && (is_wr || is_rd);
  assign exec = frame_end && cmd_ok && !blocked;

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] cmd_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_r <= CMD_RESET;
    end else if (por_s) begin
      cmd_r <= CMD_RESET;
    end else if (exec && is_wr) begin
      cmd_r <= rx_word.data & CMD_MASK;
    end
  end

  assign channel_on = cmd_r[CH_ON_HI:CH_ON_LO];
  assign load_select = cmd_r[LOAD_HI:LOAD_LO];
  assign threshold_select = cmd_r[THR_HI:THR_LO];

  // ----------------------------------------------------------------
  // response selection for the next frame
  // ----------------------------------------------------------------
  logic resp_rw_r;
  logic [1:0] resp_addr_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resp_rw_r <= 1'b0;
      resp_addr_r <= ADDR_CMD;
    end else if (por_fall) begin
      resp_rw_r <= 1'b0;
      resp_addr_r <= ADDR_CMD;
    end else if (nro_rise) begin
      resp_rw_r <= 1'b0;
      resp_addr_r <= ADDR_STAT;
    end else if (frame_end && !blocked) begin
      if (cmd_ok) begin
        resp_rw_r <= rx_word.rw;
        resp_addr_r <= rx_word.addr;
      end else begin
        resp_rw_r <= 1'b0;
        resp_addr_r <= ADDR_DIAG;
      end
    end
  end

  // ----------------------------------------------------------------
  // response word, frozen while a frame runs
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] resp_data;

  always_comb begin
    case (resp_addr_r)
      ADDR_CMD: resp_data = cmd_r;
      ADDR_DIAG: resp_data = diag_in;
      ADDR_STAT: resp_data = status_in;
      default: resp_data = DATA_ZERO;
    endcase
  end

  // link side reads this only while it stands still
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resp_word_r <= '0;
    end else if (state_r == st_idle && !cs_low_s) begin
      resp_word_r.rw <= resp_rw_r;
      resp_word_r.addr <= resp_addr_r;
      resp_word_r.data <= resp_data;
    end
  end

  // ----------------------------------------------------------------
  // frame result pulses
  // ----------------------------------------------------------------
  logic frame_ok_r;
  logic frame_bad_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      frame_ok_r <= 1'b0;
    end else begin
      frame_ok_r <= exec;
    end
  end

  // frames seen during either reset give no verdict at all
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      frame_bad_r <= 1'b0;
    end else begin
      frame_bad_r <= frame_end && !blocked && !cmd_ok;
    end
  end

  assign frame_ok = frame_ok_r;
  assign frame_bad = frame_bad_r;

endmodule

// file: dv/spi_reg_checker.sv
module spi_reg_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic select_low,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic por_active,
  input wire logic reset_output_low,
  input wire logic [spi_reg_pkg::DATA_W-1:0] diag_in,
  input wire logic [2:0] channel_on,
  input wire logic [1:0] load_select,
  input wire logic [1:0] threshold_select,
  input wire logic frame_ok,
  input wire logic frame_bad
);
  import spi_reg_pkg::*;
  logic [6:0] cfg;
  assign cfg = {threshold_select, load_select, channel_on};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_end;
    $rose(select_low) && !por_active && reset_output_low;
  endsequence
  sequence s_pulse;
    frame_ok || frame_bad;
  endsequence
  a_oe_select: assert property (serial_out_oe_n == select_low)
    else $error("enable differs from select");
  a_pulse_excl: assert property (!(frame_ok && frame_bad))
    else $error("ok and bad together");
  a_ok_single: assert property (frame_ok |=> !frame_ok)
    else $error("ok pulse too long");
  a_end_answer: assert property (s_end |-> ##[2:6] s_pulse)
    else $error("no verdict after frame");
  a_start_flag: assert property ($fell(select_low) && !por_active &&
    reset_output_low |-> serial_out == |diag_in)
    else $error("wrong flag at frame start");
  a_por_low: assert property (por_active && $past(por_active, 4) &&
    !select_low |-> !serial_out)
    else $error("output not low in power-on reset");
  a_por_zero: assert property (por_active && $past(por_active, 4)
    |-> cfg == 7'h00)
    else $error("config not cleared in power-on reset");
  a_wd_flag: assert property (!reset_output_low && !por_active &&
    !$past(reset_output_low, 4) && !$past(por_active, 4) && !select_low
    |-> serial_out == |diag_in)
    else $error("output not flag in watchdog reset");
  a_cfg_cause: assert property ($changed(cfg) && !por_active
    |-> frame_ok)
    else $error("config changed without valid frame");
endmodule

bind spi_slave_register_access spi_reg_checker spi_reg_checker_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .select_low(select_low),
  .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .por_active(por_active), .reset_output_low(reset_output_low),
  .diag_in(diag_in), .channel_on(channel_on), .load_select(load_select),
  .threshold_select(threshold_select), .frame_ok(frame_ok),
  .frame_bad(frame_bad)
);

// file: dv/spi_master_model.sv
module spi_master_model (
  output logic sclk,
  output logic select_low,
  output logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b0;
    select_low = 1'b1;
    serial_in = 1'b0;
  end
  // wrong bit counts only when the caller asks for them
  task automatic xfer(input logic [15:0] tx, input int nbits,
    output logic [15:0] rx, output logic flag);
    logic [15:0] sh;
    sh = tx;
    rx = 16'h0000;
    #3.7;
    select_low = 1'b0;
    #40;
    flag = serial_out;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      serial_in = sh[15];
      sh = {sh[14:0], 1'b0};
      #40;
      sclk = 1'b0;
      if (i < 16) rx[15 - i] = serial_out;
      #40;
    end
    select_low = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
  // clock pulses while deselected, which the device must not count
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      serial_in = ~serial_in;
      #40;
      sclk = 1'b0;
      #40;
    end
  endtask
endmodule

// file: dv/spi_slave_register_access_tb.sv
module spi_slave_register_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_reg_pkg::*;
  logic clk_sys, sys_rst, sclk, select_low, serial_in, serial_out;
  logic serial_out_oe_n, por_active, reset_output_low, frame_ok, frame_bad;
  logic [DATA_W-1:0] diag_in, status_in;
  logic [2:0] channel_on;
  logic [1:0] load_select, threshold_select;
  int err_count, n_compared, n_ok, n_bad;
  spi_slave_register_access spi_slave_register_access_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk),
    .select_low(select_low), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .por_active(por_active), .reset_output_low(reset_output_low),
    .diag_in(diag_in), .status_in(status_in), .channel_on(channel_on),
    .load_select(load_select), .threshold_select(threshold_select),
    .frame_ok(frame_ok), .frame_bad(frame_bad));
  spi_master_model spi_master_model_inst (.sclk(sclk),
    .select_low(select_low), .serial_in(serial_in),
    .serial_out(serial_out));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (frame_ok === 1'b1) n_ok++;
    if (frame_bad === 1'b1) n_bad++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // pulse_w: 2'b10 ok expected, 2'b01 bad expected
  task automatic frame(input logic [15:0] tx, input int nb,
    input logic [15:0] want, input logic flag_w,
    input logic [1:0] pulse_w, input logic [6:0] cfg_w);
    logic [15:0] rx;
    logic flag;
    int ok0, bad0;
    ok0 = n_ok;
    bad0 = n_bad;
    spi_master_model_inst.xfer(tx, nb, rx, flag);
    if (nb >= 16) chk(rx, want);
    chk(16'(serial_out_oe_n), 16'h0001);
    chk(16'(flag), 16'(flag_w));
    chk(16'((n_ok - ok0) * 2 + n_bad - bad0), 16'(pulse_w));
    chk(16'({threshold_select, load_select, channel_on}), 16'(cfg_w));
  endtask
  task automatic t_por();
    frame(16'h9fff, 16, 16'h0000, 1'b0, 2'b00, 7'h00);
    @(posedge clk_sys);
    por_active <= 1'b0;
    repeat (8) @(posedge clk_sys);
    frame(16'h2000, 16, 16'h0000, 1'b1, 2'b10, 7'h00);
    $display("t_por done");
  endtask
  task automatic t_access();
    frame(16'h9fff, 16, 16'h2a5a, 1'b1, 2'b10, 7'h7f);
    frame(16'h0000, 16, 16'h9e07, 1'b1, 2'b10, 7'h7f);
    frame(16'h4000, 16, 16'h1e07, 1'b1, 2'b10, 7'h7f);
    frame(16'h6000, 16, 16'h5234, 1'b1, 2'b01, 7'h7f);
    frame(16'ha000, 16, 16'h2a5a, 1'b1, 2'b01, 7'h7f);
    frame(16'h8000, 15, 16'h0000, 1'b1, 2'b01, 7'h7f);
    frame(16'h8000, 17, 16'h2a5a, 1'b1, 2'b01, 7'h7f);
    frame(16'h8000, 16, 16'h2a5a, 1'b1, 2'b10, 7'h00);
    spi_master_model_inst.stray(3);
    frame(16'h8a00, 16, 16'h8000, 1'b1, 2'b10, 7'h28);
    frame(16'h9400, 16, 16'h8a00, 1'b1, 2'b10, 7'h50);
    frame(16'h0000, 16, 16'h9400, 1'b1, 2'b10, 7'h50);
    $display("t_access done");
  endtask
  task automatic t_watchdog();
    @(posedge clk_sys);
    reset_output_low <= 1'b0;
    repeat (8) @(posedge clk_sys);
    frame(16'h9fff, 16, 16'hffff, 1'b1, 2'b00, 7'h50);
    @(posedge clk_sys);
    reset_output_low <= 1'b1;
    diag_in <= 13'h0000;
    repeat (8) @(posedge clk_sys);
    frame(16'h2000, 16, 16'h5234, 1'b0, 2'b10, 7'h50);
    frame(16'h0000, 16, 16'h2000, 1'b0, 2'b10, 7'h50);
    $display("t_watchdog done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    por_active = 1'b1;
    reset_output_low = 1'b1;
    diag_in = 13'h0a5a;
    status_in = 13'h1234;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    t_por();
    t_access();
    t_watchdog();
    tally_and_finish();
  end
endmodule
